// file: src/adc_seq_pkg.sv
package adc_seq_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [7:0] CSR_IDX = 8'h34;
    localparam logic [7:0] RESULT_IDX = 8'h35;
    localparam logic [7:0] CLKCFG_IDX = 8'h36;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h38;
    localparam logic [7:0] IRQ_CLEAR_IDX = 8'h39;
    localparam logic [7:0] IRQ_ENABLE_IDX = 8'h3A;

    localparam int EOC_BIT = 7;
    localparam int SPEED_BIT = 6;
    localparam int CONVERTER_ON_BIT = 5;
    localparam int CH_LSB = 0;
    localparam int CH_W = 3;
    localparam int SLOW_BIT = 3;
    localparam int IRQ_W = 2;
    localparam int IRQ_ABORT_BIT = 0;
    localparam int IRQ_OVERRUN_BIT = 1;

    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [CH_W-1:0] CH_RESET = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // Converter clock periods, expressed as the last value of the divider count.
    localparam logic [1:0] DIV1_LAST = 2'h0;
    localparam logic [1:0] DIV2_LAST = 2'h1;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    localparam logic [2:0] SAMPLE_TICKS = 3'h2;
    localparam logic [2:0] TOP_STEP = 3'h7;
    localparam logic [7:0] MSB_TRIAL = 8'h80;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_HOLD = 2'b11
    } sar_state_t;

endpackage

// file: src/sar_if.sv
interface sar_if;
    logic run;
    logic restart;
    logic slow;
    logic speed;
    logic tick;
    logic comp_high;
    logic sampling;
    logic busy;
    logic done;
    logic [7:0] approx;
    logic [7:0] result;

    modport ctrl (output run, restart, slow, speed, comp_high, input tick, sampling, busy, done, approx, result);
    modport div (input run, restart, slow, speed, output tick);
    modport engine (input run, restart, tick, comp_high, output sampling, busy, done, approx, result);
endinterface

// file: src/adc_clock_divider.sv
module adc_clock_divider
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sar_if.div bus
);
    logic [1:0] count_reg;
    logic tick_reg;
    logic [1:0] last;

    always_comb begin
        if (bus.slow) begin
            last = DIV4_LAST;
        end else if (bus.speed) begin
            last = DIV1_LAST;
        end else begin
            last = DIV2_LAST;
        end
    end

    // A restart realigns the converter clock so every conversion starts on a fresh period.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else if (!bus.run || bus.restart) begin
            count_reg <= 2'h0;
            tick_reg <= 1'b0;
        end else if (count_reg >= last) begin
            count_reg <= 2'h0;
            tick_reg <= 1'b1;
        end else begin
            count_reg <= count_reg + 2'h1;
            tick_reg <= 1'b0;
        end
    end

    assign bus.tick = tick_reg;

    a_tick_quarter: assert property (@(posedge pclk) disable iff (!presetn)
        bus.tick ##0 (bus.slow && bus.run && !bus.restart)[*3] |-> !bus.tick)
        else $error("converter clock not divided by four");

    a_tick_every: assert property (@(posedge pclk) disable iff (!presetn)
        (bus.run && !bus.slow && bus.speed && !bus.restart)[*2] |-> bus.tick)
        else $error("undivided converter clock missed a tick");
endmodule

// file: src/sar_engine.sv
module sar_engine
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    sar_if.engine bus
);
    sar_state_t state_reg;
    logic [7:0] approx_reg;
    logic [7:0] result_reg;
    logic [2:0] step_reg;
    logic [2:0] sample_cnt_reg;
    logic sampling_reg;
    logic done_reg;
    logic [7:0] decided;

    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        return 8'h01 << pos;
    endfunction

    // Keep the trial bit only when the input is at or above the trial level.
    // An input at full scale keeps every bit and one at zero keeps none.
    assign decided = bus.comp_high ? approx_reg : (approx_reg & ~bit_mask(step_reg));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            approx_reg <= RESULT_RESET;
            result_reg <= RESULT_RESET;
            step_reg <= TOP_STEP;
            sample_cnt_reg <= 3'h0;
            sampling_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!bus.run) begin
                state_reg <= ST_IDLE;
                sampling_reg <= 1'b0;
            end else if (bus.restart || state_reg == ST_IDLE) begin
                state_reg <= ST_SAMPLE;
                sampling_reg <= 1'b1;
                sample_cnt_reg <= 3'h0;
            end else if (bus.tick) begin
                case (state_reg)
                    ST_SAMPLE: begin
                        if (sample_cnt_reg == SAMPLE_TICKS - 3'h1) begin
                            state_reg <= ST_HOLD;
                            sampling_reg <= 1'b0;
                            approx_reg <= MSB_TRIAL;
                            step_reg <= TOP_STEP;
                        end else begin
                            sample_cnt_reg <= sample_cnt_reg + 3'h1;
                        end
                    end
                    ST_HOLD: begin
                        if (step_reg == 3'h0) begin
                            result_reg <= decided;
                            done_reg <= 1'b1;
                            state_reg <= ST_SAMPLE;
                            sampling_reg <= 1'b1;
                            sample_cnt_reg <= 3'h0;
                        end else begin
                            approx_reg <= decided | bit_mask(step_reg - 3'h1);
                            step_reg <= step_reg - 3'h1;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sampling_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign bus.approx = approx_reg;
    assign bus.result = result_reg;
    assign bus.done = done_reg;
    assign bus.sampling = sampling_reg;
    assign bus.busy = (state_reg != ST_IDLE);

    a_hold_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_reg == ST_HOLD) |-> (bus.approx == MSB_TRIAL && !bus.sampling))
        else $error("hold phase did not start from the top trial bit");

    a_hold_bound: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_reg == ST_HOLD) |-> ##[1:33] (bus.done || !bus.run || bus.restart))
        else $error("eight approximation steps did not finish in time");
endmodule

// file: src/adc_sequencer_control.sv
// Function
// - Input at or above top gives FFh
// - Input at or below bottom gives 00h
// - Sample phase, then eight-step isolated hold
// - Conversions repeat back to back while on
// - Setting converter_on starts continuous conversion
// - Completion sets flag, raises no interrupt
// - Result stays until next conversion ends
// - Status write while on aborts and restarts
// - Result read or status write clears flag
// - Three-bit field selects inputs zero to four
// - Clearing converter_on stops conversions
// - Converter clock divides by 2, 1 or 4
// - Idle sleep runs on, stop mode disables
// - Reserved clock configuration bits read zero
// - All three registers reset to zero
//
// The register offsets and the APB register port are this design's own decisions.
module adc_sequencer_control
    import adc_seq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_high,
    input wire logic stop_mode,
    output logic [CH_W-1:0] input_channel_select,
    output logic sample_connect,
    output logic [7:0] trial_code,
    output logic converter_power,
    output logic irq
);
    sar_if sif();

    logic eoc_reg;
    logic speed_reg;
    logic converter_on_reg;
    logic [CH_W-1:0] channel_reg;
    logic slow_reg;
    logic [7:0] result_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic restart_reg;
    logic power_reg;
    logic irq_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic access;
    logic xfer_done;
    logic run;
    logic wr_csr;
    logic wr_clkcfg;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic rd_result;
    logic clear_eoc;
    logic mapped;
    logic [7:0] read_value;
    logic [IRQ_W-1:0] irq_events;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == {2'h0, idx, 2'h0};
    endfunction

    adc_clock_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .bus(sif.div)
    );

    sar_engine u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .bus(sif.engine)
    );

    // Stop mode holds the converter off without touching the stored on bit, so it
    // resumes from a fresh sampling phase once the stop ends; idle sleep has no input here.
    assign run = converter_on_reg & ~stop_mode;
    assign sif.run = run;
    assign sif.restart = restart_reg;
    assign sif.slow = slow_reg;
    assign sif.speed = speed_reg;
    assign sif.comp_high = comparator_high;

    // The slave inserts one wait state so the read data comes from a flip-flop.
    assign access = psel & penable;
    assign xfer_done = access & pready_reg;
    assign wr_csr = xfer_done & pwrite & addr_hit(paddr, CSR_IDX);
    assign wr_clkcfg = xfer_done & pwrite & addr_hit(paddr, CLKCFG_IDX);
    assign wr_irq_clear = xfer_done & pwrite & addr_hit(paddr, IRQ_CLEAR_IDX);
    assign wr_irq_enable = xfer_done & pwrite & addr_hit(paddr, IRQ_ENABLE_IDX);
    assign rd_result = xfer_done & ~pwrite & addr_hit(paddr, RESULT_IDX);
    assign clear_eoc = wr_csr | rd_result;

    assign mapped = addr_hit(paddr, CSR_IDX) | addr_hit(paddr, RESULT_IDX) | addr_hit(paddr, CLKCFG_IDX)
        | addr_hit(paddr, IRQ_STATUS_IDX) | addr_hit(paddr, IRQ_CLEAR_IDX) | addr_hit(paddr, IRQ_ENABLE_IDX);

    always_comb begin
        read_value = 8'h00;
        if (addr_hit(paddr, CSR_IDX)) begin
            read_value[EOC_BIT] = eoc_reg;
            read_value[SPEED_BIT] = speed_reg;
            read_value[CONVERTER_ON_BIT] = converter_on_reg;
            read_value[CH_LSB +: CH_W] = channel_reg;
        end else if (addr_hit(paddr, RESULT_IDX)) begin
            read_value = result_reg;
        end else if (addr_hit(paddr, CLKCFG_IDX)) begin
            read_value[SLOW_BIT] = slow_reg;
        end else if (addr_hit(paddr, IRQ_STATUS_IDX)) begin
            read_value[IRQ_W-1:0] = irq_status_reg;
        end else if (addr_hit(paddr, IRQ_ENABLE_IDX)) begin
            read_value[IRQ_W-1:0] = irq_enable_reg;
        end
    end

    // Completion is never an interrupt source; only aborts and unread overwrites are.
    always_comb begin
        irq_events = IRQ_RESET;
        irq_events[IRQ_ABORT_BIT] = wr_csr & pwdata[CONVERTER_ON_BIT] & sif.busy;
        irq_events[IRQ_OVERRUN_BIT] = sif.done & eoc_reg & ~clear_eoc;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= access & ~pready_reg;
            if (access && !pready_reg) begin
                pslverr_reg <= ~mapped;
                prdata_reg <= pwrite ? '0 : {24'h000000, read_value};
            end else begin
                pslverr_reg <= 1'b0;
                prdata_reg <= '0;
            end
        end
    end

    // Reserved status bits are not stored, so they read as zero whatever is written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_reg <= 1'b0;
            converter_on_reg <= 1'b0;
            channel_reg <= CH_RESET;
        end else if (wr_csr) begin
            speed_reg <= pwdata[SPEED_BIT];
            converter_on_reg <= pwdata[CONVERTER_ON_BIT];
            channel_reg <= pwdata[CH_LSB +: CH_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_reg <= 1'b0;
        end else if (wr_clkcfg) begin
            slow_reg <= pwdata[SLOW_BIT];
        end
    end

    // Any status write that leaves the converter on throws away the conversion in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= wr_csr & pwdata[CONVERTER_ON_BIT];
        end
    end

    // A completion in the same cycle as a clearing access wins, so no result goes unflagged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_reg <= 1'b0;
        end else if (sif.done) begin
            eoc_reg <= 1'b1;
        end else if (clear_eoc) begin
            eoc_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= RESULT_RESET;
        end else if (sif.done) begin
            result_reg <= sif.result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= IRQ_RESET;
            irq_enable_reg <= IRQ_RESET;
            irq_reg <= 1'b0;
        end else begin
            if (wr_irq_clear) begin
                irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
            end else begin
                irq_status_reg <= irq_status_reg | irq_events;
            end
            if (wr_irq_enable) begin
                irq_enable_reg <= pwdata[IRQ_W-1:0];
            end
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_reg <= 1'b0;
        end else begin
            power_reg <= run;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign input_channel_select = channel_reg;
    assign sample_connect = sif.sampling;
    assign trial_code = sif.approx;
    assign converter_power = power_reg;
    assign irq = irq_reg;

    a_eoc_on_done: assert property (@(posedge pclk) disable iff (!presetn)
        sif.done |=> eoc_reg)
        else $error("completion flag not set after a conversion");

    a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
        sif.done |=> (result_reg == $past(sif.result) && eoc_reg))
        else $error("result and flag not updated together");

    a_result_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !sif.done |=> $stable(result_reg))
        else $error("result changed without a finished conversion");

    a_abort_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_csr && pwdata[CONVERTER_ON_BIT] && !stop_mode) ##1 !stop_mode
            |-> ##1 (sif.sampling && (!eoc_reg || $past(sif.done)) || sif.done))
        else $error("status write did not restart sampling");

    a_eoc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (clear_eoc && !sif.done) |=> !eoc_reg)
        else $error("completion flag survived a clearing access");

    a_conv_off: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_on_reg |=> (!sif.sampling && !sif.busy && !converter_power))
        else $error("converter kept running while switched off");

    a_stop_mode: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode |=> (!converter_power && !sif.busy))
        else $error("converter not disabled in stop mode");

    a_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_reg && !pwrite && addr_hit(paddr, CLKCFG_IDX))
            |=> (prdata[7:4] == 4'h0 && prdata[2:0] == 3'h0 && prdata[SLOW_BIT] == slow_reg))
        else $error("reserved clock configuration bits not zero");

    a_no_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (sif.done && !eoc_reg) |=> !irq_events[IRQ_OVERRUN_BIT] || sif.done)
        else $error("first completion raised an interrupt event");

    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |=> !pready)
        else $error("ready stood longer than one cycle");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_reg && !mapped)
        |=> (pslverr && pready))
        else $error("unmapped access gave no error");

    a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready_reg && mapped)
        |=> !pslverr)
        else $error("mapped access gave an error");

    a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready
        |-> (prdata == '0))
        else $error("read data present outside a ready cycle");

    a_chan_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_csr
        |=> (input_channel_select == $past(pwdata[2:0])))
        else $error("channel field not taken from the write");

    a_on_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_csr
        |=> (converter_on_reg == $past(pwdata[CONVERTER_ON_BIT])))
        else $error("converter on bit not taken from the write");

    a_slow_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_clkcfg
        |=> (slow_reg == $past(pwdata[SLOW_BIT])))
        else $error("slow bit not taken from the write");

    a_power_follow: assert property (@(posedge pclk) disable iff (!presetn)
        run
        |=> converter_power)
        else $error("converter not powered while on");

    a_busy_on: assert property (@(posedge pclk) disable iff (!presetn)
        run
        |=> sif.busy)
        else $error("converter idle while switched on");

    a_restart_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_csr && pwdata[CONVERTER_ON_BIT])
        |=> sif.restart)
        else $error("status write gave no restart");

    a_sample_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !run
        |=> !sample_connect)
        else $error("capacitor connected while converter off");

    a_flag_by_done: assert property (@(posedge pclk) disable iff (!presetn)
        !sif.done
        |=> !$rose(eoc_reg))
        else $error("completion flag set without a conversion");

    a_abort_event: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_csr && pwdata[CONVERTER_ON_BIT] && sif.busy)
        |=> irq_status_reg[IRQ_ABORT_BIT])
        else $error("abort did not set its status bit");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ((irq_status_reg & irq_enable_reg) != '0)
        |=> irq)
        else $error("enabled status bit raised no interrupt");

    a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        ((irq_status_reg & irq_enable_reg) == '0)
        |=> !irq)
        else $error("interrupt without an enabled status bit");
endmodule

// file: verification/analog_front_model.sv
module analog_front_model (
    input wire logic pclk,
    input wire logic [39:0] levels,
    input wire logic [2:0] input_channel_select,
    input wire logic sample_connect,
    input wire logic converter_power,
    input wire logic [7:0] trial_code,
    output logic comparator_high
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] held;
    logic [7:0] pin;
    logic toggle;

    initial begin
        held = 8'h00;
        toggle = 1'b0;
    end

    // Codes above four reach no pin, so the multiplexer output is some stray level.
    assign pin = (input_channel_select < 3'h5) ? levels[input_channel_select * 8 +: 8] : 8'hA5;

    always @(posedge pclk) begin
        toggle <= ~toggle;
        if (sample_connect) begin
            held <= pin;
        end
    end

    // An unpowered comparator gives no useful answer, so it flickers rather than resting at a kind level.
    assign comparator_high = converter_power ? (held >= trial_code) : toggle;
endmodule

// file: verification/tb_adc_sequencer_control.sv
module tb_adc_sequencer_control
    import adc_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [31:0] ON_V = 32'h0000_0020;
    localparam logic [31:0] SPEED_V = 32'h0000_0040;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic comparator_high;
    logic stop_mode;
    logic [CH_W-1:0] input_channel_select;
    logic sample_connect;
    logic [7:0] trial_code;
    logic converter_power;
    logic irq;
    logic [39:0] levels;
    logic [31:0] r;
    logic e;
    int n_fail;
    int n_compared;
    int cycles;

    adc_sequencer_control DUT (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .comparator_high(comparator_high),
        .stop_mode(stop_mode),
        .input_channel_select(input_channel_select),
        .sample_connect(sample_connect),
        .trial_code(trial_code),
        .converter_power(converter_power),
        .irq(irq)
    );

    analog_front_model front (
        .pclk(pclk),
        .levels(levels),
        .input_channel_select(input_channel_select),
        .sample_connect(sample_connect),
        .converter_power(converter_power),
        .trial_code(trial_code),
        .comparator_high(comparator_high)
    );

    always #2.5 pclk = ~pclk;

    task automatic give_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle edge so the next call never reassigns psel in the same step.
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdata,
                       output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        err = pslverr;
        chk(32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        logic derr;
        apb(1'b1, idx, d, dummy, derr);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        logic derr;
        apb(1'b0, idx, 32'h0, d, derr);
    endtask

    task automatic wait_flag();
        int n;
        n = 0;
        do begin
            rd(CSR_IDX, r);
            n++;
        end while (r[EOC_BIT] !== 1'b1 && n < 200);
        chk(32'(r[EOC_BIT]), 32'h1);
    endtask

    task automatic measure(input int div);
        int hi;
        int lo;
        int n;
        n = 0;
        while (sample_connect !== 1'b0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        while (sample_connect !== 1'b1 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        hi = 0;
        while (sample_connect === 1'b1 && hi < 500) begin
            @(posedge pclk);
            hi++;
        end
        lo = 0;
        while (sample_connect === 1'b0 && lo < 500) begin
            @(posedge pclk);
            lo++;
        end
        chk(32'(lo >= 8 * div), 32'h1);
        chk(32'(hi + lo >= 10 * div && hi + lo <= 12 * div + 3), 32'h1);
    endtask

    task automatic t_reset();
        rd(CSR_IDX, r);
        chk(r, 32'h0);
        rd(RESULT_IDX, r);
        chk(r, 32'h0);
        rd(CLKCFG_IDX, r);
        chk(r, 32'h0);
        chk(32'(input_channel_select), 32'h0);
        chk(32'(trial_code), 32'h0);
        wr(CLKCFG_IDX, 32'hFF);
        rd(CLKCFG_IDX, r);
        chk(r, 32'h08);
        wr(RESULT_IDX, 32'h77);
        rd(RESULT_IDX, r);
        chk(r, 32'h0);
        apb(1'b0, 8'h37, 32'h0, r, e);
        chk(32'(e), 32'h1);
    endtask

    task automatic t_channels();
        logic [7:0] res [5];
        wr(CSR_IDX, ON_V);
        wait_flag();
        rd(RESULT_IDX, r);
        for (int ch = 0; ch < 5; ch++) begin
            wr(CSR_IDX, ON_V | 32'(ch));
            wait_flag();
            chk(32'(input_channel_select), 32'(ch));
            rd(RESULT_IDX, r);
            res[ch] = r[7:0];
            chk(r, 32'(levels[ch * 8 +: 8]));
            rd(CSR_IDX, r);
            chk(32'(r[EOC_BIT]), 32'h0);
        end
        chk(32'(res[0]), 32'h0000_00FF);
        chk(32'(res[1]), 32'h0);
    endtask

    task automatic t_stable();
        wr(CSR_IDX, ON_V | 32'h2);
        wait_flag();
        rd(RESULT_IDX, r);
        chk(r, 32'h5A);
        levels[23:16] <= 8'h33;
        rd(RESULT_IDX, r);
        chk(r, 32'h5A);
        wait_flag();
        rd(RESULT_IDX, r);
        wait_flag();
        rd(RESULT_IDX, r);
        chk(r, 32'h33);
    endtask

    task automatic t_irq();
        wr(IRQ_CLEAR_IDX, 32'h3);
        wr(IRQ_ENABLE_IDX, 32'h1);
        wait_flag();
        wr(CSR_IDX, ON_V | 32'h2);
        rd(CSR_IDX, r);
        chk(32'(r[EOC_BIT]), 32'h0);
        rd(IRQ_STATUS_IDX, r);
        chk(r & 32'h1, 32'h1);
        chk(32'(irq), 32'h1);
        wr(IRQ_ENABLE_IDX, 32'h0);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        wr(IRQ_ENABLE_IDX, 32'h1);
        wr(IRQ_CLEAR_IDX, 32'h1);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        wr(IRQ_CLEAR_IDX, 32'h3);
        wr(IRQ_ENABLE_IDX, 32'h3);
        wait_flag();
        rd(RESULT_IDX, r);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_period();
        wr(CLKCFG_IDX, 32'h0);
        wr(CSR_IDX, ON_V | SPEED_V);
        measure(1);
        wr(CSR_IDX, ON_V);
        measure(2);
        wr(CLKCFG_IDX, 32'h08);
        measure(4);
    endtask

    task automatic t_power();
        int seen;
        stop_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(32'(converter_power), 32'h0);
        chk(32'(sample_connect), 32'h0);
        stop_mode <= 1'b0;
        seen = 0;
        repeat (100) begin
            @(posedge pclk);
            if (sample_connect === 1'b1) seen = 1;
        end
        chk(32'(seen), 32'h1);
        wr(CSR_IDX, 32'h2);
        @(posedge pclk);
        seen = 0;
        repeat (200) begin
            @(posedge pclk);
            if (sample_connect !== 1'b0 || converter_power !== 1'b0) seen = 1;
        end
        chk(32'(seen), 32'h0);
        rd(CSR_IDX, r);
        chk(32'(r[EOC_BIT]), 32'h0);
    endtask

    // Generous ceiling: the whole sequence needs only a few thousand cycles.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t timeout at cycle %h", $time, cycles);
            give_verdict();
        end
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        stop_mode = 1'b0;
        levels = {8'h3C, 8'hA5, 8'h5A, 8'h00, 8'hFF};
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        wr(CLKCFG_IDX, 32'h08);
        t_channels();
        t_stable();
        t_irq();
        t_period();
        t_power();
        give_verdict();
    end
endmodule
